/* hw/lpm_ctl_pkg.sv */
/*
  Constants and types for the low-power mode controller.
  Assumes a 32-bit APB register bus and one 125 MHz system clock.
*/
package lpm_ctl_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_STATUS  = 12'h000;
  localparam logic [11:0] OFS_MODEN   = 12'h004;
  localparam logic [11:0] OFS_CLKCFG  = 12'h008;
  localparam logic [11:0] OFS_SAVED   = 12'h00C;
  // Status word layout, bits 15..9 reserved and read as zero
  localparam int SR_W      = 16;
  localparam int SR_USED_W = 9;
  localparam int BIT_V     = 8;
  localparam int BIT_SYSCLK_GEN_CTL_HI  = 7;
  localparam int BIT_SYSCLK_GEN_CTL_LO  = 6;
  localparam int BIT_OSC   = 5;
  localparam int BIT_CPU   = 4;
  localparam int BIT_GIE   = 3;
  localparam logic [SR_W-1:0] SR_RESET   = 16'h0000;
  localparam logic [SR_W-1:0] SR_MODE_MSK = 16'h00F8;
  // Clock config layout
  localparam int CFG_SEL_BIT  = 0;
  localparam int CFG_MULT_LSB = 8;
  localparam int MULT_W       = 8;
  localparam logic [MULT_W-1:0] MULT_RESET = 8'h04;
  // Vector table
  localparam logic [15:0] VEC_BASE  = 16'hFFE0;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam int IRQ_N    = 15;
  localparam int IRQ_NMI  = 14;

  typedef struct packed {
    logic cpu_run;
    logic main_clk_on;
    logic fll_on;
    logic dc_gen_on;
    logic crystal_on;
  } mode_ctl_type;

  typedef enum logic [1:0] {st_idle, st_fetch, st_load} vec_state_type;
endpackage

/* hw/low_power_mode_control.sv */
/*
  Low-power mode controller: status word, mode decode, interrupt
  accept with vector fetch, module enables, clock generation and
  clock output select, registers over APB.
  Assumes all inputs synchronous to mclk; vector memory answers
  vec_word in the same cycle that vec_rd is high.
*/
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module low_power_mode_control
  import lpm_ctl_pkg::*;
#(
  parameter int PERIPH_N = 8,
  parameter int DIV_W    = 8
)(
  input  wire logic                mclk,
  input  wire logic                resetn,
  input  wire logic                clk_en,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic [31:0]              prdata,
  input  wire logic [IRQ_N-1:0]    irq_req,
  input  wire logic [IRQ_N-1:0]    irq_en,
  input  wire logic                return_from_irq_exec,
  output logic                     irq_taken,
  output logic [3:0]               irq_idx,
  output logic                     vec_rd,
  output logic [15:0]              vec_addr,
  input  wire logic [15:0]         vec_word,
  output logic                     pc_load,
  output logic [15:0]              pc_value,
  output mode_ctl_type             mode_ctl,
  output logic [PERIPH_N-1:0]      periph_enable,
  input  wire logic                xtal_in,
  output logic                     aux_clk,
  output logic                     main_clk,
  output logic                     clock_out_pin
);

  if (PERIPH_N < 1 || PERIPH_N > 32) $error("PERIPH_N out of range");
  if (DIV_W < 2 || DIV_W > 16) $error("DIV_W out of range");

  logic [SR_W-1:0]     status_reg;
  logic [SR_W-1:0]     saved_reg;
  logic [PERIPH_N-1:0] moden_reg;
  logic                out_sel_reg;
  logic [MULT_W-1:0]   mult_reg;
  vec_state_type       vstate_reg;
  logic [DIV_W-1:0]    div_reg;
  logic [DIV_W-1:0]    cnt_reg;
  logic [MULT_W-1:0]   edges_reg;
  logic                xtal_prev_reg;
  logic                wr_en;
  logic                rd_setup;
  logic                mapped;
  logic [IRQ_N-1:0]    eligible;
  logic                any_irq;
  logic [3:0]          pick;
  logic                accept;
  logic                aux_rise;
  logic                main_tick;

  // Mode decode from status bits
  always_comb
  begin
    mode_ctl.cpu_run     = !status_reg[BIT_CPU];
    mode_ctl.fll_on      = !status_reg[BIT_SYSCLK_GEN_CTL_LO] && !status_reg[BIT_SYSCLK_GEN_CTL_HI];
    mode_ctl.main_clk_on = !status_reg[BIT_SYSCLK_GEN_CTL_HI];
    mode_ctl.dc_gen_on   = !(status_reg[BIT_SYSCLK_GEN_CTL_HI] && status_reg[BIT_SYSCLK_GEN_CTL_LO]);
    mode_ctl.crystal_on  = !status_reg[BIT_OSC];
  end

  // APB decode; zero wait states, data set up in the setup cycle
  assign mapped   = (paddr == OFS_STATUS) || (paddr == OFS_MODEN) ||
                    (paddr == OFS_CLKCFG) || (paddr == OFS_SAVED);
  assign pready   = psel && penable && clk_en;
  assign pslverr  = pready && !mapped;
  assign wr_en    = pready && pwrite && mapped;
  assign rd_setup = clk_en && psel && !penable && !pwrite;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
    begin
      if (paddr == OFS_STATUS)
        prdata <= 32'(status_reg[SR_USED_W-1:0]);
      else if (paddr == OFS_MODEN)
        prdata <= 32'(moden_reg);
      else if (paddr == OFS_CLKCFG)
        prdata <= 32'({mult_reg, 7'h00, out_sel_reg});
      else if (paddr == OFS_SAVED)
        prdata <= 32'(saved_reg[SR_USED_W-1:0]);
      else
        prdata <= 32'h0000_0000;
    end
  end

  // Interrupt selection: NMI ignores the global enable
  always_comb
  begin
    eligible = irq_req & irq_en & {IRQ_N{status_reg[BIT_GIE]}};
    eligible[IRQ_NMI] = irq_req[IRQ_NMI];
    any_irq = |eligible;
    pick = 4'h0;
    for (int i = 0; i < IRQ_N; i++)
      if (eligible[i])
        pick = 4'(i);
  end
  assign accept = clk_en && any_irq && (vstate_reg == st_idle);

  // Status word; hardware update wins over a same-cycle bus write.
  // One save slot only: nested accepts overwrite it.
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      status_reg <= SR_RESET;
      saved_reg  <= SR_RESET;
    end
    else if (clk_en)
    begin
      if (accept)
      begin
        saved_reg  <= status_reg;
        status_reg <= status_reg & ~SR_MODE_MSK;
      end
      else if (return_from_irq_exec)
        status_reg <= saved_reg;
      else if (wr_en && paddr == OFS_STATUS)
        status_reg <= {7'h00, pwdata[SR_USED_W-1:0]};
    end
  end

  // Module enables; peripheral registers stay reachable regardless
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      moden_reg <= '0;
    else if (clk_en && wr_en && paddr == OFS_MODEN)
      moden_reg <= pwdata[PERIPH_N-1:0];
  end
  assign periph_enable = moden_reg;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      out_sel_reg <= 1'b0;
      mult_reg    <= MULT_RESET;
    end
    else if (clk_en && wr_en && paddr == OFS_CLKCFG)
    begin
      out_sel_reg <= pwdata[CFG_SEL_BIT];
      mult_reg    <= pwdata[CFG_MULT_LSB +: MULT_W];
    end
  end

  // Vector fetch sequence; reset enters it with the reset vector
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      vstate_reg <= st_fetch;
      vec_addr   <= VEC_RESET;
      irq_idx    <= 4'hF;
      irq_taken  <= 1'b0;
      pc_value   <= 16'h0000;
      pc_load    <= 1'b0;
    end
    else if (clk_en)
    begin
      irq_taken <= 1'b0;
      pc_load   <= 1'b0;
      case (vstate_reg)
        st_idle:
          if (accept)
          begin
            vstate_reg <= st_fetch;
            irq_idx    <= pick;
            irq_taken  <= 1'b1;
            vec_addr   <= VEC_BASE | {11'h000, pick, 1'b0};
          end
        st_fetch:
        begin
          pc_value   <= vec_word;
          pc_load    <= 1'b1;
          vstate_reg <= st_load;
        end
        default:
          vstate_reg <= st_idle;
      endcase
    end
  end
  assign vec_rd = (vstate_reg == st_fetch);

  // Auxiliary clock tracks the crystal while it runs
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      xtal_prev_reg <= 1'b0;
      aux_clk       <= 1'b0;
    end
    else if (clk_en)
    begin
      xtal_prev_reg <= xtal_in;
      aux_clk       <= xtal_in && mode_ctl.crystal_on;
    end
  end
  assign aux_rise = xtal_in && !xtal_prev_reg && mode_ctl.crystal_on;

  // Main clock divider, held low while stopped
  assign main_tick = mode_ctl.main_clk_on && (cnt_reg >= div_reg);
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      cnt_reg  <= '0;
      main_clk <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!mode_ctl.main_clk_on)
      begin
        cnt_reg  <= '0;
        main_clk <= 1'b0;
      end
      else if (main_tick)
      begin
        cnt_reg  <= '0;
        main_clk <= !main_clk;
      end
      else
        cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Lock loop: count main rising edges per aux period, steer divider
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      edges_reg <= '0;
      div_reg   <= DIV_W'(1);
    end
    else if (clk_en)
    begin
      if (aux_rise)
      begin
        edges_reg <= '0;
        if (mode_ctl.fll_on)
        begin
          if (edges_reg < mult_reg && div_reg > DIV_W'(1))
            div_reg <= div_reg - 1'b1;
          else if (edges_reg > mult_reg && div_reg != '1)
            div_reg <= div_reg + 1'b1;
        end
      end
      else if (main_tick && !main_clk && edges_reg != '1)
        edges_reg <= edges_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      clock_out_pin <= 1'b0;
    else if (clk_en)
      clock_out_pin <= out_sel_reg ? aux_clk : main_clk;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  chk_active_all_run: assert property (
    status_reg[7:4] == 4'h0 |-> mode_ctl == 5'h1F)
    else $error("active mode does not run everything");
  chk_level0_clocks: assert property (
    status_reg[7:4] == 4'h1 |-> mode_ctl.fll_on && mode_ctl.main_clk_on && !mode_ctl.cpu_run)
    else $error("sleep level 0 decode wrong");
  chk_level1_loop_off: assert property (
    status_reg[7:4] == 4'h5 |-> !mode_ctl.fll_on && mode_ctl.main_clk_on)
    else $error("sleep level 1 decode wrong");
  chk_level2_main_off: assert property (
    clk_en && status_reg[7:4] == 4'h9 |=> !main_clk)
    else $error("main clock still running in sleep level 2");
  chk_level3_dc_off: assert property (
    status_reg[7:4] == 4'hD |-> !mode_ctl.dc_gen_on && mode_ctl.crystal_on)
    else $error("sleep level 3 decode wrong");
  chk_level4_aux_off: assert property (
    clk_en && status_reg[7:4] == 4'hF |=> !aux_clk)
    else $error("aux clock active in sleep level 4");
  chk_accept_wakes: assert property (
    accept |=> (status_reg & SR_MODE_MSK) == 16'h0000 && saved_reg == $past(status_reg))
    else $error("accept did not save and clear mode");
  chk_return_from_irq_restores: assert property (
    clk_en && return_from_irq_exec && !accept |=> status_reg == $past(saved_reg))
    else $error("return did not restore status word");
  chk_vector_range: assert property (vec_rd |-> vec_addr >= VEC_BASE && !vec_addr[0])
    else $error("vector address outside table");
  chk_pc_loaded: assert property (
    clk_en && vec_rd |=> pc_load && pc_value == $past(vec_word))
    else $error("vector word not loaded into pc");
  chk_nmi_taken: assert property (
    accept && irq_req[IRQ_NMI] |=> irq_taken && irq_idx == 4'hE)
    else $error("nmi not taken first");
  chk_reserved_zero: assert property (status_reg[15:9] == 7'h00)
    else $error("reserved status bits set");
  chk_clkout_select: assert property (
    clk_en |=> clock_out_pin == ($past(out_sel_reg) ? $past(aux_clk) : $past(main_clk)))
    else $error("clock output wrong source");
endmodule

/* test/lpm_partner.sv */
/*
  Far-side model: vector memory and interrupt sources.
  Assumes fire pulses come from the bench, synchronous to mclk.
*/
`timescale 1ns/100ps
module lpm_partner
  import lpm_ctl_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic [IRQ_N-1:0] fire,
  input  wire logic             irq_taken,
  input  wire logic [3:0]       irq_idx,
  input  wire logic             vec_rd,
  input  wire logic [15:0]      vec_addr,
  output logic      [IRQ_N-1:0] irq_req,
  output logic      [15:0]      vec_word
);
  logic [15:0] junk_reg;
  // Source holds its request until accepted, then drops it
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      irq_req <= '0;
    else if (irq_taken)
      irq_req <= (irq_req | fire) & ~(IRQ_N'(1) << irq_idx);
    else
      irq_req <= irq_req | fire;
  end
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      junk_reg <= 16'h0000;
    else
      junk_reg <= junk_reg + 16'h3C5B;
  end
  // Outside a fetch the bus churns, so a stale word never passes
  assign vec_word = vec_rd ? ~vec_addr : junk_reg;
endmodule

/* test/low_power_mode_control_tb.sv */
/*
  Self-checking bench for the low-power mode controller.
  Assumes the package constants and the lpm_partner model.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("FAIL %0t got %0h exp %0h", $time, a, b); end end
module low_power_mode_control_tb;
  import lpm_ctl_pkg::*;
  logic         mclk, resetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic         return_from_irq_exec, irq_taken, vec_rd, pc_load, xtal_in, aux_clk;
  logic         main_clk, clock_out_pin, e, pa, pm;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, q;
  logic [14:0]  irq_req, irq_en, fire;
  logic [3:0]   irq_idx;
  logic [15:0]  vec_addr, vec_word, pc_value;
  logic [7:0]   periph_enable;
  logic [2:0]   xdiv;
  mode_ctl_type mode_ctl;
  int           n_errors, checks, cyc, n, na, nm;
  logic [7:0]   modes [6] = '{8'h00, 8'h10, 8'h50, 8'h90, 8'hD0, 8'hF0};
  logic [4:0]   ctl [6] = '{5'h1F, 5'h0F, 5'h0B, 5'h03, 5'h01, 5'h00};

  low_power_mode_control dut (.mclk, .resetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .prdata, .irq_req, .irq_en, .return_from_irq_exec,
    .irq_taken, .irq_idx, .vec_rd, .vec_addr, .vec_word, .pc_load, .pc_value,
    .mode_ctl, .periph_enable, .xtal_in, .aux_clk, .main_clk, .clock_out_pin);
  lpm_partner partner (.mclk, .resetn, .fire, .irq_taken, .irq_idx, .vec_rd,
    .vec_addr, .irq_req, .vec_word);

  always #4 mclk = ~mclk;
  // Crystal stand-in, eight mclk cycles a period
  always @(posedge mclk)
  begin
    xdiv <= xdiv + 3'h1;
    xtal_in <= xdiv[2];
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  task wrap_up();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // Only the cycle ceiling ends a wait here
    while (pready !== 1'b1)
      @(posedge mclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task rd_chk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h00000000);
    `CHK(q, x)
  endtask

  task pulse(input logic [14:0] m, input logic [14:0] en);
    @(posedge mclk);
    fire <= m;
    irq_en <= en;
    @(posedge mclk);
    fire <= 15'h0000;
    #1;
  endtask

  task wait_irq(input logic [3:0] idx);
    logic [15:0] v;
    v = VEC_BASE | (16'(idx) << 1);
    n = 0;
    while (irq_taken !== 1'b1 && n < 10)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHK(irq_idx, idx)
    `CHK(vec_addr, v)
    `CHK(vec_rd, 1'b1)
    `CHK(mode_ctl, 5'h1F)
    @(posedge mclk);
    #1;
    `CHK(pc_load, 1'b1)
    `CHK(pc_value, ~v)
  endtask

  initial
  begin
    {mclk, resetn, psel, penable, pwrite, return_from_irq_exec, xtal_in} = '0;
    {paddr, pwdata, irq_en, fire, xdiv} = '0;
    clk_en = 1'b1;
    {n_errors, checks, cyc} = '0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    n = 0;
    while (pc_load !== 1'b1 && n < 10)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHK(pc_value, ~VEC_RESET)
    rd_chk(OFS_STATUS, 32'h00000000);
    `CHK(mode_ctl, 5'h1F)
    rd_chk(OFS_CLKCFG, 32'h00000400);
    apb(1'b1, OFS_STATUS, 32'h0000FFFF);
    rd_chk(OFS_STATUS, 32'h000001FF);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, OFS_STATUS, {24'h000000, modes[i]});
      `CHK(mode_ctl, ctl[i])
      // Registered clocks take one edge to follow a mode change
      @(posedge mclk);
      #1;
      na = 0;
      nm = 0;
      repeat (40)
      begin
        pa = aux_clk;
        pm = main_clk;
        @(posedge mclk);
        #1;
        na += int'(aux_clk !== pa);
        nm += int'(main_clk !== pm);
      end
      `CHK(na > 0, ctl[i][0])
      `CHK(nm > 0, ctl[i][3])
    end
    apb(1'b1, OFS_STATUS, 32'h00000000);
    for (int s = 0; s < 2; s++)
    begin
      apb(1'b1, OFS_CLKCFG, 32'h00000400 | s);
      repeat (24)
      begin
        pa = s ? aux_clk : main_clk;
        @(posedge mclk);
        #1;
        `CHK(clock_out_pin, pa)
      end
    end
    apb(1'b1, OFS_MODEN, 32'h000000A5);
    `CHK(periph_enable, 8'hA5)
    rd_chk(OFS_MODEN, 32'h000000A5);
    apb(1'b0, 12'h010, 32'h00000000);
    `CHK({e, q}, 33'h100000000)
    // Masked request must wait for the global enable
    apb(1'b1, OFS_STATUS, 32'h000000D0);
    pulse(15'h0008, 15'h3FFF);
    repeat (6)
    begin
      @(posedge mclk);
      #1;
      `CHK(irq_taken, 1'b0)
    end
    apb(1'b1, OFS_STATUS, 32'h000000D8);
    wait_irq(4'h3);
    rd_chk(OFS_SAVED, 32'h000000D8);
    rd_chk(OFS_STATUS, 32'h00000000);
    @(posedge mclk);
    return_from_irq_exec <= 1'b1;
    @(posedge mclk);
    return_from_irq_exec <= 1'b0;
    #1;
    `CHK(mode_ctl, 5'h01)
    rd_chk(OFS_STATUS, 32'h000000D8);
    apb(1'b1, OFS_STATUS, 32'h000000F0);
    pulse(15'h4000, 15'h0000);
    wait_irq(4'hE);
    // Clock enable low must freeze the running main clock
    @(posedge mclk);
    clk_en <= 1'b0;
    @(posedge mclk);
    #1;
    pa = main_clk;
    pm = aux_clk;
    repeat (6) @(posedge mclk);
    clk_en <= 1'b1;
    #1;
    `CHK({main_clk, aux_clk}, {pa, pm})
    wrap_up();
  end
endmodule
